// ===== pkg/acf_pkg.sv
// Shared constants and types for the ASCII command frame codec.
// Assumes byte-wide character streams on one system clock.
package acf_pkg;
    localparam logic [7:0] ACF_SOH       = 8'h01; // Frame start, serial link
    localparam logic [7:0] ACF_LF        = 8'h0a; // Frame terminator
    localparam logic [7:0] ACF_CR        = 8'h0d; // Carriage return, serial link
    localparam logic [7:0] ACF_DIGIT0    = 8'h30; // ASCII '0'
    localparam logic [7:0] ACF_ALPHA_OFS = 8'h37; // ASCII 'A' minus ten
    localparam logic [7:0] ACF_NIB_TEN   = 8'h0a; // First nibble shown as letter
    localparam logic [7:0] ACF_FCS_MAIN  = 8'h13; // Check error main code, BCD
    localparam logic [7:0] ACF_FCS_SUB   = 8'h00; // Check error sub code, BCD
    localparam logic [1:0] ACF_CODE_LAST = 2'h3;  // Index of last code character
    localparam logic [1:0] ACF_FCS_LEN   = 2'h2;  // Check characters per frame
    localparam logic [3:0] ACF_HDR_SOH   = 4'h0;  // Header step: start character
    localparam logic [3:0] ACF_HDR_CODE0 = 4'h1;  // Header step: first code char
    localparam logic [3:0] ACF_HDR_MAIN  = 4'h5;  // Header step: main code tens
    localparam logic [3:0] ACF_HDR_LAST  = 4'h8;  // Header step: sub code units
    localparam logic [3:0] ACF_TRL_FCSH  = 4'h0;  // Trailer step: check high
    localparam logic [3:0] ACF_TRL_FCSL  = 4'h1;  // Trailer step: check low
    localparam logic [3:0] ACF_TRL_CR    = 4'h2;  // Trailer step: carriage return
    localparam logic [3:0] ACF_TRL_LF    = 4'h3;  // Trailer step: terminator
    localparam int         ACF_CHAR_W    = 8;     // Character width
    localparam int         ACF_FIFO_D    = 4;     // Transmit FIFO depth

    // Receive parser states
    typedef enum logic [1:0] {ACF_RX_IDLE, ACF_RX_CODE, ACF_RX_DATA, ACF_RX_CRLF} acf_rx_t;
    // Response builder states
    typedef enum logic [1:0] {ACF_TX_IDLE, ACF_TX_HDR, ACF_TX_DATA, ACF_TX_TRL} acf_tx_t;
endpackage : acf_pkg

// ===== pkg/acf_stream_if.sv
// Valid/ready character stream between the codec and its FIFO.
// Assumes both ends sit on the same clock.
interface acf_stream_if #(parameter int W = 8);
    logic         valid; // Source offers data
    logic         ready; // Sink accepts data
    logic [W-1:0] data;  // Character
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : acf_stream_if

// ===== rtl/acf_fifo.sv
// Small synchronous FIFO for the response character path.
// Assumes one clock and an asynchronous active-low reset.
module acf_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    input  wire logic clock_i,  // System clock
    input  wire logic resetn_i, // Asynchronous reset, active low
    acf_stream_if.snk in_s,     // Filling side
    acf_stream_if.src out_s     // Draining side
);
    localparam int AW = $clog2(D);
    localparam logic [AW:0] FULL = AW'(D) == '0 ? (AW+1)'(D) : (AW+1)'(D);

    // Whole FIFO state
    typedef struct packed {
        logic [D-1:0][W-1:0] mem; // Storage
        logic [AW-1:0]       wr;  // Write pointer
        logic [AW-1:0]       rd;  // Read pointer
        logic [AW:0]         cnt; // Fill level
    } acf_fifo_st_t;

    acf_fifo_st_t s;      // Registered state
    acf_fifo_st_t next_s; // Next state
    logic         push;   // Write this cycle
    logic         pop;    // Read this cycle

    // Honest flags straight from the fill level
    assign in_s.ready  = (s.cnt != FULL);
    assign out_s.valid = (s.cnt != '0);
    assign out_s.data  = s.mem[s.rd];
    assign push        = in_s.valid && in_s.ready;
    assign pop         = out_s.valid && out_s.ready;

    // Pointer and level update
    always_comb begin
        next_s = s;
        if (push) begin
            next_s.mem[s.wr] = in_s.data;
            next_s.wr        = AW'((s.wr == AW'(D - 1)) ? 0 : s.wr + 1'b1);
        end
        if (pop) begin
            next_s.rd = AW'((s.rd == AW'(D - 1)) ? 0 : s.rd + 1'b1);
        end
        if (push && !pop) begin
            next_s.cnt = s.cnt + 1'b1;
        end else if (pop && !push) begin
            next_s.cnt = s.cnt - 1'b1;
        end
    end

    // State register
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule : acf_fifo

// ===== rtl/acf_codec.sv
// ASCII command frame codec: parses command lines, builds response lines.
// Assumes a byte stream from a link receiver, a byte sink with ready, and
// a mode input that stays steady while frames are in flight.

// Overview of operation
// - Every frame ends with line feed
// - Serial frames begin with start character
// - Serial: check chars and CR before LF
// - Check is XOR after start through data
// - Check byte sent as two printable chars
// - Network frames: code, data, LF only
// - Response: echoed code, result, result data
// - First four characters are command code
// - Check mismatch answers main code 13
// - Result code is four decimal digits
module acf_codec
    import acf_pkg::*;
(
    input  wire logic        clock_i,          // System clock
    input  wire logic        resetn_i,         // Asynchronous reset, active low
    input  wire logic        serial_mode_i,    // High: serial framing, low: network
    input  wire logic        rx_valid_i,       // Received character strobe
    input  wire logic [7:0]  rx_data_i,        // Received character
    output logic             cmd_valid_o,      // Good command ended, one cycle
    output logic             cmd_fcs_err_o,    // Bad check, one cycle
    output logic [31:0]      cmd_code_o,       // Command code, first char on top
    output logic             cmd_data_valid_o, // Command data character strobe
    output logic [7:0]       cmd_data_o,       // Command data character
    input  wire logic        rsp_start_i,      // Begin a response
    input  wire logic [31:0] rsp_code_i,       // Echoed command code
    input  wire logic [7:0]  rsp_main_i,       // Main result code, BCD
    input  wire logic [7:0]  rsp_sub_i,        // Sub result code, BCD
    input  wire logic        rsp_nodata_i,     // Response has no result data
    input  wire logic        rsp_data_valid_i, // Result data offered
    input  wire logic [7:0]  rsp_data_i,       // Result data character
    input  wire logic        rsp_data_last_i,  // Last result data character
    output logic             rsp_data_ready_o, // Result data taken
    output logic             rsp_busy_o,       // Response in progress
    output logic             tx_valid_o,       // Outgoing character valid
    output logic [7:0]       tx_data_o,        // Outgoing character
    input  wire logic        tx_ready_i        // Link takes the character
);
    // Whole codec state
    typedef struct packed {
        acf_rx_t     rx_st;   // Parser state
        logic [1:0]  rx_idx;  // Code character index
        logic [31:0] rx_code; // Code being collected
        logic [7:0]  rx_acc;  // Running check of released characters
        logic [7:0]  h0;      // Newest held character
        logic [7:0]  h1;      // Older held character
        logic [1:0]  hcnt;    // Held characters
        logic        fcs_ok;  // Check matched at carriage return
        logic        cmd_v;   // Command done pulse
        logic        fcs_e;   // Check error pulse
        logic [31:0] code;    // Last command code
        logic        dv;      // Data strobe
        logic [7:0]  dd;      // Data character
        acf_tx_t     tx_st;   // Builder state
        logic [3:0]  tx_idx;  // Header or trailer step
        logic        tx_ser;  // Serial framing for this response
        logic        nodata;  // Skip data phase
        logic [31:0] tx_code; // Echoed code
        logic [15:0] tx_res;  // Main and sub code, BCD
        logic [7:0]  tx_acc;  // Outgoing check
        logic        held;    // Result character held
        logic [7:0]  hold;    // Held result character
        logic        hlast;   // Held character is last
        logic        rdy;     // Result data ready
        logic        busy;    // Response in progress
        logic        epend;   // Check error answer pending
        logic        ov;      // Output valid
        logic [7:0]  od;      // Output character
    } acf_st_t;

    acf_st_t     s;         // Registered state
    acf_st_t     next_s;    // Next state
    logic        push_v;    // Character offered to FIFO
    logic [7:0]  push_d;    // Character offered to FIFO
    logic        push;      // Character enters FIFO
    logic [7:0]  hdr_c;     // Header character for current step
    logic [7:0]  trl_c;     // Trailer character for current step

    acf_stream_if #(.W(ACF_CHAR_W)) fin_s ();  // Builder to FIFO
    acf_stream_if #(.W(ACF_CHAR_W)) fout_s (); // FIFO to output stage

    // Nibble to ASCII hex digit, upper case
    function automatic logic [7:0] hex_c(input logic [3:0] n);
        logic [7:0] w;
        w = {4'h0, n};
        hex_c = (w < ACF_NIB_TEN) ? (ACF_DIGIT0 + w) : (ACF_ALPHA_OFS + w);
    endfunction : hex_c

    // BCD digit to ASCII decimal digit
    function automatic logic [7:0] dec_c(input logic [3:0] n);
        dec_c = ACF_DIGIT0 | {4'h0, n};
    endfunction : dec_c

    // Header and trailer character selection
    always_comb begin
        hdr_c = ACF_SOH;
        if (s.tx_idx >= ACF_HDR_CODE0 && s.tx_idx < ACF_HDR_MAIN) begin
            hdr_c = s.tx_code[8'(31 - 8 * (s.tx_idx - ACF_HDR_CODE0)) -: 8];
        end else if (s.tx_idx >= ACF_HDR_MAIN) begin
            hdr_c = dec_c(s.tx_res[8'(15 - 4 * (s.tx_idx - ACF_HDR_MAIN)) -: 4]);
        end
        trl_c = ACF_LF;
        if (s.tx_idx == ACF_TRL_FCSH) begin
            trl_c = hex_c(s.tx_acc[7:4]);
        end else if (s.tx_idx == ACF_TRL_FCSL) begin
            trl_c = hex_c(s.tx_acc[3:0]);
        end else if (s.tx_idx == ACF_TRL_CR) begin
            trl_c = ACF_CR;
        end
    end

    // Character offered to the FIFO
    always_comb begin
        push_v = 1'b0;
        push_d = s.hold;
        if (s.tx_st == ACF_TX_HDR) begin
            push_v = 1'b1;
            push_d = hdr_c;
        end else if (s.tx_st == ACF_TX_TRL) begin
            push_v = 1'b1;
            push_d = trl_c;
        end else if (s.tx_st == ACF_TX_DATA) begin
            push_v = s.held;
        end
    end

    assign fin_s.valid  = push_v;
    assign fin_s.data   = push_d;
    assign push         = push_v && fin_s.ready;
    assign fout_s.ready = !s.ov || tx_ready_i;

    // Transmit FIFO; a full FIFO stalls the builder
    acf_fifo #(.W(ACF_CHAR_W), .D(ACF_FIFO_D)) u_fifo (
        .clock_i  (clock_i),
        .resetn_i (resetn_i),
        .in_s     (fin_s),
        .out_s    (fout_s)
    );

    // Parser, builder and output stage next-state logic
    always_comb begin
        next_s       = s;
        next_s.cmd_v = 1'b0;
        next_s.fcs_e = 1'b0;
        next_s.dv    = 1'b0;
        // Parser
        if (rx_valid_i) begin
            if (serial_mode_i && rx_data_i == ACF_SOH) begin
                next_s.rx_st  = ACF_RX_CODE;
                next_s.rx_idx = '0;
                next_s.rx_acc = '0;
                next_s.hcnt   = '0;
            end else begin
                case (s.rx_st)
                    ACF_RX_IDLE: begin
                        // Network frames start with their first code char
                        if (!serial_mode_i && rx_data_i != ACF_LF) begin
                            next_s.rx_st   = ACF_RX_CODE;
                            next_s.rx_code = {24'h0, rx_data_i};
                            next_s.rx_acc  = rx_data_i;
                            next_s.rx_idx  = 2'h1;
                            next_s.hcnt    = '0;
                        end
                    end
                    ACF_RX_CODE: begin
                        if (rx_data_i == ACF_LF) begin
                            next_s.rx_st = ACF_RX_IDLE; // Short frame dropped
                        end else begin
                            next_s.rx_code = {s.rx_code[23:0], rx_data_i};
                            next_s.rx_acc  = s.rx_acc ^ rx_data_i;
                            next_s.rx_idx  = s.rx_idx + 1'b1;
                            if (s.rx_idx == ACF_CODE_LAST) begin
                                next_s.rx_st = ACF_RX_DATA;
                            end
                        end
                    end
                    ACF_RX_DATA: begin
                        if (rx_data_i == ACF_LF) begin
                            // Network ends here; serial without CR is dropped
                            next_s.rx_st = ACF_RX_IDLE;
                            next_s.cmd_v = !serial_mode_i;
                            next_s.code  = serial_mode_i ? s.code : s.rx_code;
                        end else if (serial_mode_i && rx_data_i == ACF_CR) begin
                            // Last two held characters are the check
                            next_s.rx_st  = ACF_RX_CRLF;
                            next_s.fcs_ok = (s.hcnt == ACF_FCS_LEN)
                                && (s.h1 == hex_c(s.rx_acc[7:4]))
                                && (s.h0 == hex_c(s.rx_acc[3:0]));
                        end else if (!serial_mode_i) begin
                            next_s.dv = 1'b1;
                            next_s.dd = rx_data_i;
                        end else begin
                            // Hold two characters back so check chars never leak
                            next_s.h0 = rx_data_i;
                            next_s.h1 = s.h0;
                            if (s.hcnt == ACF_FCS_LEN) begin
                                next_s.dv     = 1'b1;
                                next_s.dd     = s.h1;
                                next_s.rx_acc = s.rx_acc ^ s.h1;
                            end else begin
                                next_s.hcnt = s.hcnt + 1'b1;
                            end
                        end
                    end
                    ACF_RX_CRLF: begin
                        next_s.rx_st = ACF_RX_IDLE;
                        if (rx_data_i == ACF_LF) begin
                            next_s.code  = s.rx_code;
                            next_s.cmd_v = s.fcs_ok;
                            next_s.fcs_e = !s.fcs_ok;
                        end
                    end
                    default: next_s.rx_st = ACF_RX_IDLE;
                endcase
            end
        end
        // Pending check-error answer; a new error wins over the clear
        next_s.epend = s.epend || next_s.fcs_e;
        // Builder
        case (s.tx_st)
            ACF_TX_IDLE: begin
                if (s.epend || rsp_start_i) begin
                    next_s.tx_st  = ACF_TX_HDR;
                    next_s.busy   = 1'b1;
                    next_s.tx_ser = serial_mode_i;
                    next_s.tx_idx = serial_mode_i ? ACF_HDR_SOH : ACF_HDR_CODE0;
                    next_s.tx_acc = '0;
                    if (s.epend) begin
                        next_s.epend   = next_s.fcs_e;
                        next_s.tx_code = s.code;
                        next_s.tx_res  = {ACF_FCS_MAIN, ACF_FCS_SUB};
                        next_s.nodata  = 1'b1;
                    end else begin
                        next_s.tx_code = rsp_code_i;
                        next_s.tx_res  = {rsp_main_i, rsp_sub_i};
                        next_s.nodata  = rsp_nodata_i;
                    end
                end
            end
            ACF_TX_HDR: begin
                if (push) begin
                    if (s.tx_idx != ACF_HDR_SOH) begin
                        next_s.tx_acc = s.tx_acc ^ hdr_c;
                    end
                    next_s.tx_idx = s.tx_idx + 1'b1;
                    if (s.tx_idx == ACF_HDR_LAST) begin
                        next_s.tx_st  = s.nodata ? ACF_TX_TRL : ACF_TX_DATA;
                        next_s.tx_idx = s.tx_ser ? ACF_TRL_FCSH : ACF_TRL_LF;
                    end
                end
            end
            ACF_TX_DATA: begin
                if (push) begin
                    next_s.held   = 1'b0;
                    next_s.tx_acc = s.tx_acc ^ s.hold;
                    if (s.hlast) begin
                        next_s.tx_st = ACF_TX_TRL;
                    end
                end
            end
            ACF_TX_TRL: begin
                if (push) begin
                    next_s.tx_idx = s.tx_idx + 1'b1;
                    if (s.tx_idx == ACF_TRL_LF) begin
                        next_s.tx_st = ACF_TX_IDLE;
                        next_s.busy  = 1'b0;
                    end
                end
            end
            default: next_s.tx_st = ACF_TX_IDLE;
        endcase
        // Result data capture into the one-character holding slot
        if (s.rdy && rsp_data_valid_i) begin
            next_s.held  = 1'b1;
            next_s.hold  = rsp_data_i;
            next_s.hlast = rsp_data_last_i;
        end
        next_s.rdy = (next_s.tx_st == ACF_TX_DATA) && !next_s.held;
        // Output register stage
        if (fout_s.ready) begin
            next_s.ov = fout_s.valid;
            if (fout_s.valid) begin
                next_s.od = fout_s.data;
            end
        end
    end

    // State register
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from flip-flops
    assign cmd_valid_o      = s.cmd_v;
    assign cmd_fcs_err_o    = s.fcs_e;
    assign cmd_code_o       = s.code;
    assign cmd_data_valid_o = s.dv;
    assign cmd_data_o       = s.dd;
    assign rsp_data_ready_o = s.rdy;
    assign rsp_busy_o       = s.busy;
    assign tx_valid_o       = s.ov;
    assign tx_data_o        = s.od;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    // Command completion follows a received terminator
    lf_ends_cmd_a: assert property (cmd_valid_o |-> $past(rx_valid_i && rx_data_i == ACF_LF))
        else $error("command completed without line feed");
    // Serial response opens with the start character
    soh_first_a: assert property ((push && s.tx_st == ACF_TX_HDR && s.tx_idx == ACF_HDR_SOH)
        |-> (push_d == ACF_SOH && s.tx_ser))
        else $error("serial response does not open with start char");
    // Carriage return is followed by the terminator step
    cr_then_lf_a: assert property ((push && s.tx_st == ACF_TX_TRL && s.tx_idx == ACF_TRL_CR)
        |-> push_d == ACF_CR ##1 (s.tx_st == ACF_TX_TRL && s.tx_idx == ACF_TRL_LF))
        else $error("carriage return not followed by terminator step");
    // Check errors only come from a failed comparison
    fcs_cause_a: assert property (cmd_fcs_err_o |-> (!$past(s.fcs_ok) && !cmd_valid_o))
        else $error("check error without mismatch");
    // High check character is the printable hex of the XOR check
    fcs_hex_a: assert property ((push && s.tx_st == ACF_TX_TRL && s.tx_idx == ACF_TRL_FCSH)
        |-> (push_d == hex_c(s.tx_acc[7:4]) && push_d >= ACF_DIGIT0))
        else $error("check character not hex");
    // Network responses never send start, check or CR
    net_bare_a: assert property ((s.busy && !s.tx_ser) |->
        !(s.tx_st == ACF_TX_HDR && s.tx_idx == ACF_HDR_SOH)
        && !(s.tx_st == ACF_TX_TRL && s.tx_idx != ACF_TRL_LF))
        else $error("network response carries serial framing");
    // Check error answered with main code 13
    fcs_answer_a: assert property ((cmd_fcs_err_o && s.tx_st == ACF_TX_IDLE)
        |=> (s.busy && s.tx_res == {ACF_FCS_MAIN, ACF_FCS_SUB}))
        else $error("check error not answered with code 13");
    // Code phase never runs past the fourth character
    code_four_a: assert property ((s.rx_st == ACF_RX_CODE && $past(s.rx_st) == ACF_RX_CODE)
        |-> s.rx_idx != '0 || !$past(rx_valid_i))
        else $error("code phase length wrong");
    // Result code characters are decimal digits
    res_dec_a: assert property ((push && s.tx_st == ACF_TX_HDR && s.tx_idx >= ACF_HDR_MAIN)
        |-> (push_d[7:4] == ACF_DIGIT0[7:4]))
        else $error("result code character not decimal");

    good_cmd_c: cover property (cmd_valid_o);
    bad_fcs_c:  cover property (cmd_fcs_err_o ##[1:60] (tx_valid_o && tx_data_o == ACF_LF));
    data_rsp_c: cover property (s.tx_st == ACF_TX_DATA ##[1:40] s.tx_st == ACF_TX_TRL);
endmodule : acf_codec

// ===== sim/acf_host_model.sv
// Host model: sends command lines and takes response characters.
// Assumes the codec clock; its sink stalls every third cycle.
module acf_host_model
    import acf_pkg::*;
(
    input  wire logic       clock_i,    // System clock
    output logic            rx_valid_o, // Character strobe
    output logic [7:0]      rx_data_o,  // Character to codec
    input  wire logic       tx_valid_i, // Response char offered
    input  wire logic [7:0] tx_data_i,  // Response char
    output logic            tx_ready_o  // Sink takes char
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] got[$];     // Response characters taken
    logic [1:0] cyc = 2'h0; // Stall pacing
    initial rx_valid_o = 1'b0;
    initial rx_data_o = 8'h00;
    initial tx_ready_o = 1'b0;
    // Records a character mid-cycle when valid and ready will meet at the next edge
    always @(negedge clock_i) begin
        if (tx_valid_i === 1'b1 && tx_ready_o === 1'b1) got.push_back(tx_data_i);
    end
    // Sink stalls one cycle in three
    always @(posedge clock_i) begin
        cyc <= (cyc == 2'h2) ? 2'h0 : cyc + 2'h1;
        tx_ready_o <= (cyc != 2'h0);
    end
    // Upper-case hex digit of a nibble
    function automatic logic [7:0] hex(input logic [3:0] v);
        return (v < 4'ha) ? ACF_DIGIT0 + 8'(v) : ACF_ALPHA_OFS + 8'(v);
    endfunction : hex
    // Builds one line; bad spoils the high check character
    function automatic void build(input string s, input bit ser, input bit bad,
                                  ref logic [7:0] q[$]);
        logic [7:0] x = 8'h00;
        q.delete();
        foreach (s[i]) x ^= s[i];
        if (ser) q.push_back(ACF_SOH);
        foreach (s[i]) q.push_back(s[i]);
        if (ser) q.push_back(hex(x[7:4] ^ {3'h0, bad}));
        if (ser) q.push_back(hex(x[3:0]));
        if (ser) q.push_back(ACF_CR);
        q.push_back(ACF_LF);
    endfunction : build
    // One character a cycle, then the data line shows a changed value
    task automatic send(input string s, input bit ser, input bit bad);
        logic [7:0] q[$];
        build(s, ser, bad, q);
        foreach (q[i]) begin
            @(posedge clock_i);
            rx_valid_o <= 1'b1;
            rx_data_o <= q[i];
        end
        @(posedge clock_i);
        rx_valid_o <= 1'b0;
        rx_data_o <= ~q[q.size() - 1];
    endtask : send
endmodule : acf_host_model

// ===== sim/acf_codec_tb.sv
// Bench: commands in both framings, a check error, responses.
// Assumes the host model drives the link side of the codec.
module acf_codec_tb
    import acf_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock_i = 1'b0, resetn_i, serial_mode_i, rx_valid_i, rsp_start_i, rsp_nodata_i;
    logic        rsp_data_valid_i, rsp_data_last_i, tx_ready_i, tx_valid_o, cmd_valid_o;
    logic        cmd_fcs_err_o, cmd_data_valid_o, rsp_data_ready_o, rsp_busy_o;
    logic [7:0]  rx_data_i, rsp_main_i, rsp_sub_i, rsp_data_i, cmd_data_o, tx_data_o, dq[$];
    logic [31:0] rsp_code_i, cmd_code_o;
    int          errors = 0, checked = 0, n_ok = 0, n_bad = 0;
    acf_codec DUT (.clock_i, .resetn_i, .serial_mode_i, .rx_valid_i, .rx_data_i, .cmd_valid_o,
        .cmd_fcs_err_o, .cmd_code_o, .cmd_data_valid_o, .cmd_data_o, .rsp_start_i, .rsp_code_i,
        .rsp_main_i, .rsp_sub_i, .rsp_nodata_i, .rsp_data_valid_i, .rsp_data_i, .rsp_data_last_i,
        .rsp_data_ready_o, .rsp_busy_o, .tx_valid_o, .tx_data_o, .tx_ready_i);
    acf_host_model host (.clock_i, .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i),
        .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o), .tx_ready_o(tx_ready_i));
    initial forever #10 clock_i = ~clock_i;
    // Records what the parser hands out, mid-cycle while the pulses stand
    always @(negedge clock_i) begin
        if (cmd_data_valid_o === 1'b1) dq.push_back(cmd_data_o);
        if (cmd_valid_o === 1'b1) n_ok++;
        if (cmd_fcs_err_o === 1'b1) n_bad++;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic chk_q(input string what, input logic [7:0] e[$], input logic [7:0] g[$]);
        chk({what, " length"}, e.size(), g.size());
        foreach (e[i]) if (i < g.size()) chk(what, e[i], g[i]);
    endtask : chk_q
    // One command line; good or spoiled check
    task automatic command(input bit ser, input bit bad, input string s);
        logic [7:0] e[$];
        int         ok0 = n_ok;
        int         bad0 = n_bad;
        dq.delete();
        serial_mode_i <= ser;
        host.send(s, ser, bad);
        repeat (3) @(posedge clock_i);
        chk("good count", ok0 + !bad, n_ok);
        chk("bad count", bad0 + bad, n_bad);
        chk("code", {s[0], s[1], s[2], s[3]}, cmd_code_o);
        for (int i = 4; i < s.len(); i++) e.push_back(s[i]);
        if (!bad) chk_q("data", e, dq);
    endtask : command
    // Waits for a whole response line and compares it
    task automatic expect_rsp(input bit ser, input string s);
        logic [7:0] q[$];
        int         n = 0;
        host.build(s, ser, 1'b0, q);
        while (host.got.size() < q.size() && n++ < 300) @(posedge clock_i);
        chk_q("response", q, host.got);
        host.got.delete();
    endtask : expect_rsp
    // Starts a response and offers its result data
    task automatic respond(input bit ser, input logic [7:0] sub, input string d, input string e);
        int   n;
        logic seen;
        serial_mode_i <= ser;
        rsp_code_i <= "GETC";
        rsp_main_i <= 8'h12;
        rsp_sub_i <= sub;
        rsp_nodata_i <= (d.len() == 0);
        rsp_start_i <= 1'b1;
        @(posedge clock_i);
        rsp_start_i <= 1'b0;
        foreach (d[i]) begin
            rsp_data_valid_i <= 1'b1;
            rsp_data_i <= d[i];
            rsp_data_last_i <= (i == d.len() - 1);
            n = 0;
            // Ready is registered: its mid-cycle value is what the next edge samples
            do begin
                @(negedge clock_i);
                seen = (rsp_data_ready_o === 1'b1);
                @(posedge clock_i);
            end while (!seen && ++n < 50);
        end
        rsp_data_valid_i <= 1'b0;
        rsp_data_last_i <= 1'b0;
        expect_rsp(ser, e);
    endtask : respond
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop
    // Main sequence
    initial begin
        {resetn_i, serial_mode_i, rsp_start_i, rsp_nodata_i, rsp_data_valid_i} = 5'h00;
        {rsp_data_last_i, rsp_data_i, rsp_main_i, rsp_sub_i, rsp_code_i} = '0;
        repeat (6) @(posedge clock_i);
        resetn_i <= 1'b1;
        command(1'b1, 1'b0, "RDID -a 1");
        command(1'b1, 1'b1, "TEST 9");
        expect_rsp(1'b1, "TEST1300");
        command(1'b0, 1'b0, "GETC ab");
        respond(1'b0, 8'h00, "xy", "GETC1200xy");
        respond(1'b1, 8'h34, "", "GETC1234");
        report_and_stop();
    end
    // Watchdog against a hang
    initial begin
        repeat (3000) @(posedge clock_i);
        errors++;
        report_and_stop();
    end
endmodule : acf_codec_tb
